// file: hdl/ifl_defs.vh
// Purpose: constants for the channel 4-6 input fault latch bank
// Assumes: page 0 register space, 7-bit register locations, 8-bit data
// Notes: definitions only
`ifndef IFL_DEFS_VH
`define IFL_DEFS_VH
`define IFL_PAGE0 8'h00
`define IFL_ADDR_CH4 7'h31
`define IFL_ADDR_CH5 7'h32
`define IFL_ADDR_CH6 7'h33
`define IFL_ADDR_OVP 7'h35
`define IFL_ADDR_OVN 7'h36
`define IFL_LATCH_RESET 8'h00
`define IFL_BIT_OPEN 7
`define IFL_BIT_PAIR 6
`define IFL_BIT_PGND 5
`define IFL_BIT_MGND 4
`define IFL_BIT_PBIAS 3
`define IFL_BIT_MBIAS 2
`define IFL_BIT_PBAT 1
`define IFL_BIT_MBAT 0
`define IFL_BIT_OV_CH4 4
`define IFL_BIT_OV_CH5 3
`define IFL_BIT_OV_CH6 2
`endif

// file: hdl/ifl_fault_bank.v
// Contract
// - channel 4 fault latch is read-only at page 0 location 0x31 and resets to zero.
// - channel 5 fault latch sits at page 0 location 0x32, resets to zero, six-channel only.
// - channel 6 fault latch sits at page 0 location 0x33, resets to zero, six-channel only.
// - bit 7 reads one once an open input has been seen on the channel.
// - bit 6 reads one once the two inputs of the channel were found shorted together.
// - bit 5 flags positive input shorted to ground and bit 4 the negative input.
// - bit 3 flags positive input shorted to mic bias and bit 2 the negative input.
// - bit 1 flags positive input shorted to battery and bit 0 the negative input.
// - every flag holds until a read clears it; host writes do not clear it.
// - bit 0 of each latch also clears when page 0 register 54 decimal is read.
// - channels 5 and 6 use channel 4's field layout on their own pins.
// - readback register 0x36 bit 4 holds channel 4 negative over-voltage, cleared by reading 0x31.
// - readback register 0x35 bit 4 holds channel 4 positive over-voltage, cleared by reading 49 decimal.
//
// Purpose: latched input fault status for channels 4, 5 and 6
// Assumes: control port delivers one-cycle regRead/regWrite strobes with page and address
// Notes: read data is registered one cycle after the strobe
`timescale 1ns/1ps
`include "ifl_defs.vh"
module ifl_fault_bank #(
	parameter SIX_CHANNEL = 1
) (
	clk,
	resetn,
	regPage,
	regAddr,
	regRead,
	regWrite,
	regWdata,
	regRdata,
	regRvalid,
	ch4Fault,
	ch5Fault,
	ch6Fault,
	ovPositive,
	ovNegative
);
	input wire clk;
	input wire resetn;
	input wire [7:0] regPage;
	input wire [6:0] regAddr;
	input wire regRead;
	input wire regWrite;
	input wire [7:0] regWdata;
	output reg [7:0] regRdata;
	output reg regRvalid;
	// detector levels/pulses, bit order as the latch layout
	input wire [7:0] ch4Fault;
	input wire [7:0] ch5Fault;
	input wire [7:0] ch6Fault;
	// over-voltage detectors for channels 4..6, index 0 is channel 4
	input wire [2:0] ovPositive;
	input wire [2:0] ovNegative;

	wire [7:0] ch4Sync;
	wire [7:0] ch5Sync;
	wire [7:0] ch6Sync;
	wire [2:0] ovPSync;
	wire [2:0] ovNSync;
	wire [7:0] ch4Flags;
	wire [7:0] ch5Flags;
	wire [7:0] ch6Flags;
	wire [7:0] ch4Set;
	wire [7:0] ch5Set;
	wire [7:0] ch6Set;

	reg [2:0] ovP_reg;
	reg [2:0] ovN_reg;
	reg [2:0] ovP_next;
	reg [2:0] ovN_next;
	reg [7:0] rdMux;

	wire page0;
	wire rd4;
	wire rd5;
	wire rd6;
	wire rdOvn;

	wire [7:0] clr4;
	wire [7:0] clr5;
	wire [7:0] clr6;
	wire [7:0] ovpView;
	wire [7:0] ovnView;

	function hit;
		input [6:0] a;
		input [6:0] target;
		input rd;
		input pg;
		begin
			hit = rd & pg & (a == target);
		end
	endfunction

	// same field order on every channel, bit positions from the defs
	function [7:0] layout;
		input [7:0] raw;
		begin
			layout = 8'h00;
			layout[`IFL_BIT_OPEN] = raw[7];
			layout[`IFL_BIT_PAIR] = raw[6];
			layout[`IFL_BIT_PGND] = raw[5];
			layout[`IFL_BIT_MGND] = raw[4];
			layout[`IFL_BIT_PBIAS] = raw[3];
			layout[`IFL_BIT_MBIAS] = raw[2];
			layout[`IFL_BIT_PBAT] = raw[1];
			layout[`IFL_BIT_MBAT] = raw[0];
		end
	endfunction

	// channel read clears all eight, a 0x36 read only bit 0, the negative battery bit
	function [7:0] clrMask;
		input rdCh;
		input rdOv;
		begin
			clrMask = {8{rdCh}};
			clrMask[`IFL_BIT_MBAT] = rdCh | rdOv;
		end
	endfunction

	// four-channel variants keep channels 5 and 6 silent
	function [7:0] gateUpper;
		input [7:0] v;
		begin
			gateUpper = (SIX_CHANNEL != 0) ? v : 8'h00;
		end
	endfunction

	// sticky step for a 3-bit over-voltage column, set wins
	function [2:0] ovStep;
		input [2:0] cur;
		input [2:0] clr;
		input [2:0] set;
		begin
			ovStep = (cur & ~clr) | set;
			if (SIX_CHANNEL == 0) begin
				ovStep[2:1] = 2'h0;
			end
		end
	endfunction

	function [7:0] ovView;
		input [2:0] flags;
		begin
			ovView = 8'h00;
			ovView[`IFL_BIT_OV_CH4] = flags[0];
			ovView[`IFL_BIT_OV_CH5] = flags[1];
			ovView[`IFL_BIT_OV_CH6] = flags[2];
		end
	endfunction

	// write data is accepted and dropped: these latches are read-only
	wire unusedWrite;
	assign unusedWrite = regWrite & (|regWdata);

	ifl_sync2 #(
		.W(8)
	) uSync4 (
		.clk(clk),
		.resetn(resetn),
		.asyncIn(ch4Fault),
		.syncOut(ch4Sync)
	);

	ifl_sync2 #(
		.W(8)
	) uSync5 (
		.clk(clk),
		.resetn(resetn),
		.asyncIn(ch5Fault),
		.syncOut(ch5Sync)
	);

	ifl_sync2 #(
		.W(8)
	) uSync6 (
		.clk(clk),
		.resetn(resetn),
		.asyncIn(ch6Fault),
		.syncOut(ch6Sync)
	);

	ifl_sync2 #(
		.W(3)
	) uSyncP (
		.clk(clk),
		.resetn(resetn),
		.asyncIn(ovPositive),
		.syncOut(ovPSync)
	);

	ifl_sync2 #(
		.W(3)
	) uSyncN (
		.clk(clk),
		.resetn(resetn),
		.asyncIn(ovNegative),
		.syncOut(ovNSync)
	);

	assign page0 = (regPage == `IFL_PAGE0);
	assign rd4 = hit(regAddr, `IFL_ADDR_CH4, regRead, page0);
	assign rd5 = hit(regAddr, `IFL_ADDR_CH5, regRead, page0);
	assign rd6 = hit(regAddr, `IFL_ADDR_CH6, regRead, page0);
	assign rdOvn = hit(regAddr, `IFL_ADDR_OVN, regRead, page0);

	// only reads clear; writes never reach the clear masks
	assign clr4 = clrMask(rd4, rdOvn);
	assign clr5 = clrMask(rd5, rdOvn);
	assign clr6 = clrMask(rd6, rdOvn);

	// four-channel variants tie the upper channels off
	assign ch4Set = layout(ch4Sync);
	assign ch5Set = gateUpper(layout(ch5Sync));
	assign ch6Set = gateUpper(layout(ch6Sync));

	// bit map 7 open, 6 pair, 5/4 gnd, 3/2 bias, 1/0 battery
	ifl_latch8 uLatch4 (
		.clk(clk),
		.resetn(resetn),
		.setIn(ch4Set),
		.clearMask(clr4),
		.flags_reg(ch4Flags)
	);
	ifl_latch8 uLatch5 (
		.clk(clk),
		.resetn(resetn),
		.setIn(ch5Set),
		.clearMask(clr5),
		.flags_reg(ch5Flags)
	);
	ifl_latch8 uLatch6 (
		.clk(clk),
		.resetn(resetn),
		.setIn(ch6Set),
		.clearMask(clr6),
		.flags_reg(ch6Flags)
	);

	// over-voltage flags clear on a read of their channel latch, set wins
	always @* begin
		ovP_next = ovStep(ovP_reg, {rd6, rd5, rd4}, ovPSync);
		ovN_next = ovStep(ovN_reg, {rd6, rd5, rd4}, ovNSync);
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ovP_reg <= 3'h0;
		end else begin
			ovP_reg <= ovP_next;
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ovN_reg <= 3'h0;
		end else begin
			ovN_reg <= ovN_next;
		end
	end

	assign ovpView = ovView(ovP_reg);
	assign ovnView = ovView(ovN_reg);

	// value sampled before the clear lands, so a read sees the flags it clears
	always @* begin
		rdMux = 8'h00;
		if (page0) begin
			case (regAddr)
				`IFL_ADDR_CH4: rdMux = ch4Flags;
				`IFL_ADDR_CH5: rdMux = ch5Flags;
				`IFL_ADDR_CH6: rdMux = ch6Flags;
				`IFL_ADDR_OVP: rdMux = ovpView;
				`IFL_ADDR_OVN: rdMux = ovnView;
				default: rdMux = 8'h00;
			endcase
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regRead;
		end
	end

	// data holds between reads so a slow host can pick it up late
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdata <= 8'h00;
		end else begin
			if (regRead) begin
				regRdata <= rdMux;
			end
		end
	end
endmodule // ifl_fault_bank

// file: hdl/ifl_latch8.v
// Purpose: eight sticky fault flags with read-clear
// Assumes: set and clear are one-cycle-qualified on clk
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
`include "ifl_defs.vh"
module ifl_latch8 (
	clk,
	resetn,
	setIn,
	clearMask,
	flags_reg
);
	input wire clk;
	input wire resetn;
	input wire [7:0] setIn;
	input wire [7:0] clearMask;
	output reg [7:0] flags_reg;
	wire [7:0] flags_next;
	// a fault still present keeps the flag set through the clear, since set wins
	assign flags_next = (flags_reg & ~clearMask) | setIn;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_reg <= `IFL_LATCH_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end
endmodule // ifl_latch8

// file: hdl/ifl_sync2.v
// Purpose: two-stage synchroniser for a bus of detector levels
// Assumes: inputs come from the analog domain
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module ifl_sync2 #(
	parameter W = 8
) (
	clk,
	resetn,
	asyncIn,
	syncOut
);
	input wire clk;
	input wire resetn;
	input wire [W-1:0] asyncIn;
	output reg [W-1:0] syncOut;
	reg [W-1:0] stage1_reg;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1_reg <= {W{1'b0}};
			syncOut <= {W{1'b0}};
		end else begin
			stage1_reg <= asyncIn;
			syncOut <= stage1_reg;
		end
	end
endmodule // ifl_sync2

// file: tb/ifl_fault_bank_properties.sv
// Purpose: port checks for ifl_fault_bank
// Assumes: one-cycle read strobe
// Notes: bound from the bench
`timescale 1ns/1ps
module ifl_fault_bank_chk (
	input wire clk,
	input wire resetn,
	input wire [7:0] regPage,
	input wire [6:0] regAddr,
	input wire regRead,
	input wire [7:0] regRdata,
	input wire regRvalid,
	input wire [7:0] ch4Fault
);
	reg [2:0] calm_reg;
	wire rd0 = regRead && regPage == 8'h00;
	wire rd4 = rd0 && regAddr == 7'h31;
	// quiet long enough to empty the synchroniser
	always @(posedge clk or negedge resetn) begin
		if (!resetn) calm_reg <= 3'h0;
		else if (ch4Fault != 8'h00) calm_reg <= 3'h0;
		else if (calm_reg != 3'h7) calm_reg <= calm_reg + 3'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_ans; regRead |=> regRvalid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_one; !regRead |=> !regRvalid; endproperty
	a_one: assert property (p_one) else $error("stray valid");
	property p_hold; !regRead |=> $stable(regRdata); endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_page; regRead && regPage != 8'h00 |=> regRdata == 8'h00; endproperty
	a_page: assert property (p_page) else $error("other page");
	property p_gap; rd0 && regAddr == 7'h34 |=> regRdata == 8'h00; endproperty
	a_gap: assert property (p_gap) else $error("unmapped");
	property p_ovp; rd0 && regAddr == 7'h35 |=> (regRdata & 8'hE3) == 8'h00; endproperty
	a_ovp: assert property (p_ovp) else $error("ovp bits");
	property p_ovn; rd0 && regAddr == 7'h36 |=> (regRdata & 8'hE3) == 8'h00; endproperty
	a_ovn: assert property (p_ovn) else $error("ovn bits");
	property p_clr; rd4 ##2 rd4 && calm_reg == 3'h7 |=> regRdata == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("not cleared");
	c_ov: cover property (rd0 && regAddr == 7'h36);
	c_clr: cover property (rd4 ##2 rd4);
	c_pg: cover property (regRead && regPage != 8'h00);
endmodule // ifl_fault_bank_chk

// file: tb/ifl_fault_bank_tb.sv
// Purpose: self-checking bench for ifl_fault_bank
// Assumes: 10 MHz clock, one-cycle detector pulses
// Notes: flags read after the synchroniser settles
`timescale 1ns/1ps
module ifl_fault_bank_tb;
	reg clk = 1'b0;
	reg resetn = 1'b0;
	reg [7:0] regPage = 8'h00;
	reg [6:0] regAddr = 7'h00;
	reg regRead = 1'b0;
	reg regWrite = 1'b0;
	reg [7:0] regWdata = 8'h00;
	reg [23:0] flt = 24'h0;
	reg [2:0] ovPositive = 3'h0;
	reg [2:0] ovNegative = 3'h0;
	wire [7:0] regRdata;
	wire regRvalid;
	reg [31:0] seed = 32'd94806;
	reg [7:0] got;
	integer err_count = 0;
	integer num_checks = 0;
	integer c;
	integer b;
	ifl_fault_bank #(.SIX_CHANNEL(1)) ifl_fault_bank_inst (.clk(clk), .resetn(resetn),
		.regPage(regPage), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
		.regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
		.ch4Fault(flt[7:0]), .ch5Fault(flt[15:8]), .ch6Fault(flt[23:16]),
		.ovPositive(ovPositive), .ovNegative(ovNegative));
	initial forever #50 clk = ~clk;
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	function [7:0] ovExp(input [2:0] r);
		ovExp = {3'h0, r[0], r[1], r[2], 2'h0};
	endfunction
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("wrong value at %0t: %h vs %h", $time, seen, exp);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks %0d errors %0d", num_checks, err_count);
			if (err_count == 0 && num_checks > 0) $display("verification passed");
			else $display("verification failed");
			$finish;
		end
	endtask
	task rd(input [7:0] pg, input [6:0] a);
		integer i;
		begin
			@(posedge clk);
			regPage <= pg;
			regAddr <= a;
			regRead <= 1'b1;
			@(posedge clk);
			regRead <= 1'b0;
			#1;
			for (i = 0; i < 4 && regRvalid !== 1'b1; i = i + 1) @(posedge clk) #1;
			if (regRvalid !== 1'b1) begin
				err_count = err_count + 1;
				final_report;
			end
			got = regRdata;
		end
	endtask
	// keep holds the fault as a level
	task hit(input [23:0] f, input [2:0] p, input [2:0] n, input keep);
		begin
			@(posedge clk);
			flt <= f;
			ovPositive <= p;
			ovNegative <= n;
			@(posedge clk);
			if (!keep) flt <= 24'h0;
			ovPositive <= 3'h0;
			ovNegative <= 3'h0;
			repeat (8) @(posedge clk);
		end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		for (c = 0; c < 4; c = c + 1) begin
			rd(8'h00, 7'h31 + c[6:0]);
			chk(got, 8'h00);
		end
		for (c = 0; c < 24; c = c + 1) begin
			hit(24'h1 << c, 3'h0, 3'h0, 1'b0);
			@(posedge clk);
			regAddr <= 7'h31 + c[6:0] / 7'h8;
			regWrite <= 1'b1;
			@(posedge clk);
			regWrite <= 1'b0;
			rd(8'h00, 7'h31 + c[6:0] / 7'h8);
			chk(got, 8'h1 << c[2:0]);
			rd(8'h00, 7'h31 + c[6:0] / 7'h8);
			chk(got, 8'h00);
		end
		for (c = 0; c < 20; c = c + 1) begin
			seed = xs(seed);
			hit(seed[23:0], seed[26:24], seed[29:27], 1'b0);
			rd(8'h01, 7'h31);
			chk(got, 8'h00);
			rd(8'h00, 7'h35);
			chk(got, ovExp(seed[26:24]));
			rd(8'h00, 7'h36);
			chk(got, ovExp(seed[29:27]));
			for (b = 0; b < 3; b = b + 1) begin
				rd(8'h00, 7'h31 + b[6:0]);
				chk(got, seed[8 * b +: 8] & 8'hFE);
			end
			rd(8'h00, 7'h35);
			chk(got, 8'h00);
			rd(8'h00, 7'h36);
			chk(got, 8'h00);
		end
		hit(24'h000080, 3'h0, 3'h0, 1'b1);
		rd(8'h00, 7'h31);
		chk(got, 8'h80);
		rd(8'h00, 7'h31);
		chk(got, 8'h80);
		hit(24'h0, 3'h0, 3'h0, 1'b0);
		rd(8'h00, 7'h31);
		chk(got, 8'h80);
		rd(8'h00, 7'h31);
		chk(got, 8'h00);
		final_report;
	end
endmodule // ifl_fault_bank_tb
bind ifl_fault_bank ifl_fault_bank_chk ifl_fault_bank_chk_inst (.clk(clk), .resetn(resetn),
	.regPage(regPage), .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata),
	.regRvalid(regRvalid), .ch4Fault(ch4Fault));
